// ===== ppx_pkg.sv
// Constants and carriers for the priority pin crossbar.
// Assumes one 10 MHz system clock and an active-low asynchronous reset.
package ppx_pkg;

   // Pin space: P0.0-P2.7 are indices 0-23, P3.0-P3.4 are 24-28
   localparam int unsigned PPX_PINS = 29;
   localparam int unsigned PPX_CAND = 20;
   localparam int unsigned PPX_FN = 21;
   localparam int unsigned PPX_SKIP_W = 24;

   // Function slots in priority order
   localparam logic [4:0] PPX_FN_TX = 5'h00;
   localparam logic [4:0] PPX_FN_RX = 5'h01;
   localparam logic [4:0] PPX_FN_SCK = 5'h02;
   localparam logic [4:0] PPX_FN_MISO = 5'h03;
   localparam logic [4:0] PPX_FN_MOSI = 5'h04;
   localparam logic [4:0] PPX_FN_SEL = 5'h05;
   localparam logic [4:0] PPX_FN_SDA = 5'h06;
   localparam logic [4:0] PPX_FN_SCL = 5'h07;
   localparam logic [4:0] PPX_FN_CP0 = 5'h08;
   localparam logic [4:0] PPX_FN_CP0A = 5'h09;
   localparam logic [4:0] PPX_FN_CP1 = 5'h0a;
   localparam logic [4:0] PPX_FN_CP1A = 5'h0b;
   localparam logic [4:0] PPX_FN_CLK = 5'h0c;
   localparam logic [4:0] PPX_FN_CH0 = 5'h0d;
   localparam logic [4:0] PPX_FN_CH4 = 5'h11;
   localparam logic [4:0] PPX_FN_CNTIN = 5'h12;
   localparam logic [4:0] PPX_FN_T0 = 5'h13;
   localparam logic [4:0] PPX_FN_T1 = 5'h14;
   localparam logic [4:0] PPX_FN_NONE = 5'h1f;

   // Fixed serial port pins
   localparam logic [4:0] PPX_TX_PIN = 5'h04;
   localparam logic [4:0] PPX_RX_PIN = 5'h05;

   // function_select_low fields
   localparam int unsigned PPX_LO_UART = 0;
   localparam int unsigned PPX_LO_SPI = 1;
   localparam int unsigned PPX_LO_SMB = 2;
   localparam int unsigned PPX_LO_CLK = 3;
   localparam int unsigned PPX_LO_CP0 = 4;
   localparam int unsigned PPX_LO_CP0A = 5;
   localparam int unsigned PPX_LO_CP1 = 6;
   localparam int unsigned PPX_LO_CP1A = 7;

   // function_select_high fields
   localparam int unsigned PPX_HI_CH_LSB = 0;
   localparam int unsigned PPX_HI_CH_MSB = 2;
   localparam int unsigned PPX_HI_CNTIN = 3;
   localparam int unsigned PPX_HI_T0 = 4;
   localparam int unsigned PPX_HI_T1 = 5;
   localparam int unsigned PPX_HI_ENABLE = 6;

   typedef struct packed {
      logic [7:0] function_select_low;
      logic [7:0] function_select_high;
      logic [PPX_SKIP_W-1:0] port_skip_mask;
      logic [PPX_PINS-1:0] port_output_mode;
      logic [PPX_PINS-1:0] port_latch;
      logic spi_four_wire;
   } ppx_cfg_s;

   typedef struct packed {
      logic [PPX_FN-1:0] value;
      logic [PPX_FN-1:0] drive;
   } ppx_fn_drive_s;

   typedef struct packed {
      logic [PPX_PINS-1:0] level;
      logic [PPX_PINS-1:0] enable;
   } ppx_pin_drive_s;

   typedef struct packed {
      logic [PPX_PINS-1:0] used;
      logic [PPX_PINS-1:0][4:0] fn;
      ppx_pin_drive_s pin;
      logic [PPX_PINS-1:0] port_read;
      logic [PPX_FN-1:0] fn_in;
   } ppx_state_s;

   localparam ppx_state_s PPX_STATE_RST = '0;

endpackage

// ===== ppx_crossbar.sv
// Priority pin crossbar: places enabled peripheral signals on port pins.
// Assumes configuration and pin levels are synchronous to clk_sys.
`timescale 1ns/10ps

// What this block does
// - Fixed rank per function, serial port first
// - Each function takes lowest free unskipped pin
// - Serial transmit P0.4, receive P0.5 always
// - Assigned pin excluded for later functions
// - Skip mask bits count as taken pins
// - Two-wire data, then clock, each take the next free pin
// - Leftover pins stay general purpose pins
// - Slave select pinned only in 4-wire mode
// - Port read returns actual pin level
// - Only P0.0-P2.3 receive peripheral functions
// - Special signals unplaced; software sets skips
// - Skip bit n matches pin n
// - Per-pin push-pull or open-drain selection
// - Disabled matrix leaves pins plain inputs
// - Disabled matrix turns all drivers off
// - Channel count field routes first k channels
// - Two-wire bus pins always open-drain
module ppx_crossbar (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire ppx_pkg::ppx_cfg_s cfg,
   input wire ppx_pkg::ppx_fn_drive_s fn_drive,
   input wire logic [ppx_pkg::PPX_PINS-1:0] pin_in,
   output ppx_pkg::ppx_pin_drive_s pin_drive,
   output logic [ppx_pkg::PPX_PINS-1:0] port_read,
   output logic [ppx_pkg::PPX_FN-1:0] fn_in,
   output logic [ppx_pkg::PPX_PINS-1:0] pin_assigned
);
   import ppx_pkg::*;

   ppx_state_s st_q;
   ppx_state_s st_d;

   // Counter channel k is routed while the count field is above k
   function automatic logic chan_routed(logic [2:0] count, logic [4:0] f);
      logic [4:0] idx;
      idx = f - PPX_FN_CH0;
      return ({2'h0, count} > idx);
   endfunction

   // Whether function slot f is requested by the select fields
   function automatic logic fn_enabled(ppx_cfg_s c, logic [4:0] f);
      logic [2:0] ch;
      logic on;
      ch = c.function_select_high[PPX_HI_CH_MSB:PPX_HI_CH_LSB];
      case (f)
         PPX_FN_TX, PPX_FN_RX: begin
            on = c.function_select_low[PPX_LO_UART];
         end
         PPX_FN_SCK, PPX_FN_MISO, PPX_FN_MOSI: begin
            on = c.function_select_low[PPX_LO_SPI];
         end
         PPX_FN_SEL: begin
            on = c.function_select_low[PPX_LO_SPI] & c.spi_four_wire;
         end
         PPX_FN_SDA, PPX_FN_SCL: begin
            on = c.function_select_low[PPX_LO_SMB];
         end
         PPX_FN_CP0: begin
            on = c.function_select_low[PPX_LO_CP0];
         end
         PPX_FN_CP0A: begin
            on = c.function_select_low[PPX_LO_CP0A];
         end
         PPX_FN_CP1: begin
            on = c.function_select_low[PPX_LO_CP1];
         end
         PPX_FN_CP1A: begin
            on = c.function_select_low[PPX_LO_CP1A];
         end
         PPX_FN_CLK: begin
            on = c.function_select_low[PPX_LO_CLK];
         end
         PPX_FN_CNTIN: begin
            on = c.function_select_high[PPX_HI_CNTIN];
         end
         PPX_FN_T0: begin
            on = c.function_select_high[PPX_HI_T0];
         end
         PPX_FN_T1: begin
            on = c.function_select_high[PPX_HI_T1];
         end
         default: begin
            // Channel k of the counter array needs count above k
            if (f >= PPX_FN_CH0 && f <= PPX_FN_CH4) begin
               on = chan_routed(ch, f);
            end else begin
               on = 1'b0;
            end
         end
      endcase
      return on;
   endfunction

   // Lowest candidate pin not yet taken, or none
   function automatic logic [4:0] lowest_free(logic [PPX_CAND-1:0] taken);
      logic [4:0] pick;
      pick = PPX_FN_NONE;
      for (int i = PPX_CAND - 1; i >= 0; i--) begin
         if (!taken[i]) begin
            pick = 5'(i);
         end
      end
      return pick;
   endfunction

   // Driver on, except where an open-drain pin must float high
   function automatic logic drive_on(logic od, logic want, logic lvl);
      logic on;
      on = want;
      if (od) begin
         on = want & ~lvl;
      end
      return on;
   endfunction

   always_comb begin
      logic [PPX_CAND-1:0] taken;
      logic [4:0] pick;
      logic [4:0] f;
      logic lvl;
      logic want;
      logic od;
      logic xbar_on;
      taken = '0;
      pick = PPX_FN_NONE;
      f = PPX_FN_NONE;
      lvl = 1'b0;
      want = 1'b0;
      od = 1'b0;
      xbar_on = cfg.function_select_high[PPX_HI_ENABLE];
      st_d = PPX_STATE_RST;

      // Allocation, rebuilt every cycle from present settings
      if (xbar_on) begin
         // Skip bit n stands for pin n; only P0.0-P2.3 are candidates
         taken = cfg.port_skip_mask[PPX_CAND-1:0];
         if (fn_enabled(cfg, PPX_FN_TX)) begin
            // Serial port pins are fixed, whatever the skip mask says
            taken[PPX_TX_PIN] = 1'b1;
            taken[PPX_RX_PIN] = 1'b1;
            st_d.used[PPX_TX_PIN] = 1'b1;
            st_d.fn[PPX_TX_PIN] = PPX_FN_TX;
            st_d.used[PPX_RX_PIN] = 1'b1;
            st_d.fn[PPX_RX_PIN] = PPX_FN_RX;
         end
         // Slots walked in rank order below the serial port
         // Special signals hold no slot; software skips their pins
         for (int s = 2; s < PPX_FN; s++) begin
            if (fn_enabled(cfg, 5'(s))) begin
               pick = lowest_free(taken);
               if (pick != PPX_FN_NONE) begin
                  st_d.used[pick] = 1'b1;
                  st_d.fn[pick] = 5'(s);
                  taken[pick] = 1'b1;
               end
            end
         end
      end

      // Pins above the candidate range never carry a function
      st_d.used[PPX_PINS-1:PPX_CAND] = '0;
      st_d.fn[PPX_PINS-1:PPX_CAND] = '0;

      // Pin drivers
      for (int i = 0; i < PPX_PINS; i++) begin
         // Unassigned pins fall back to the port latch
         lvl = cfg.port_latch[i];
         want = 1'b1;
         od = ~cfg.port_output_mode[i];
         if (st_d.used[i]) begin
            f = st_d.fn[i];
            lvl = fn_drive.value[f];
            want = fn_drive.drive[f];
            if (f == PPX_FN_SDA || f == PPX_FN_SCL) begin
               od = 1'b1;
            end
         end
         if (od) begin
            // Open-drain only pulls low; a one floats
            st_d.pin.level[i] = 1'b0;
            st_d.pin.enable[i] = xbar_on & drive_on(od, want, lvl);
         end else begin
            st_d.pin.level[i] = lvl;
            st_d.pin.enable[i] = xbar_on & drive_on(od, want, lvl);
         end
      end

      // Reads always see the pin itself
      st_d.port_read = pin_in;
      // Peripheral inputs idle high when not pinned out
      st_d.fn_in = '1;
      for (int i = 0; i < PPX_CAND; i++) begin
         if (st_d.used[i]) begin
            st_d.fn_in[st_d.fn[i]] = pin_in[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= PPX_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_drive = st_q.pin;
   assign port_read = st_q.port_read;
   assign fn_in = st_q.fn_in;
   assign pin_assigned = st_q.used;

endmodule // ppx_crossbar

// ===== ppx_crossbar_props.sv
// Port-level assertions for the priority pin crossbar.
// Assumes it is bound into ppx_crossbar, one clock, async low reset.
`timescale 1ns/10ps
module ppx_crossbar_props (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire ppx_pkg::ppx_cfg_s cfg,
   input wire ppx_pkg::ppx_fn_drive_s fn_drive,
   input wire logic [28:0] pin_in,
   input wire ppx_pkg::ppx_pin_drive_s pin_drive,
   input wire logic [28:0] port_read,
   input wire logic [20:0] fn_in,
   input wire logic [28:0] pin_assigned
);
   import ppx_pkg::*;
   logic en;
   assign en = cfg.function_select_high[PPX_HI_ENABLE];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   read_pin_a: assert property (resetn |=>
      port_read == $past(pin_in))
      else $error("port read differs from pin");
   off_nodrive_a: assert property (!en |=> pin_drive.enable == '0)
      else $error("driver on while matrix off");
   off_noasg_a: assert property (resetn && !en |=>
      !pin_assigned && &fn_in)
      else $error("pin placed while matrix off");
   uart_fixed_a: assert property (resetn && en &&
      cfg.function_select_low[0] |=>
      pin_assigned[5:4] == 2'b11 && fn_in[1] == $past(pin_in[5]))
      else $error("serial pins not fixed");
   upper_gpio_a: assert property (pin_assigned[28:20] == '0)
      else $error("pin above range placed");
   skip_kept_a: assert property (1'b1 |=> (pin_assigned[19:0] &
      $past(cfg.port_skip_mask[19:0]) & 20'hfffcf) == '0)
      else $error("skipped pin placed");
   sel_mode_a: assert property (resetn && en &&
      cfg.function_select_low == 8'h02 && cfg.port_skip_mask[3:0] == '0 &&
      cfg.function_select_high[5:0] == '0 |=>
      pin_assigned[3] == $past(cfg.spi_four_wire)) else $error("select pin");
   smb_pair_a: assert property (resetn && en &&
      cfg.function_select_low == 8'h04 && cfg.port_skip_mask[1:0] == '0 |=>
      pin_assigned[1:0] == 2'b11 && pin_drive.level[1:0] == '0)
      else $error("two-wire pins wrong");
endmodule // ppx_crossbar_props
bind ppx_crossbar ppx_crossbar_props chk_u (.clk_sys(clk_sys),
   .resetn(resetn), .cfg(cfg), .fn_drive(fn_drive), .pin_in(pin_in),
   .pin_drive(pin_drive), .port_read(port_read), .fn_in(fn_in),
   .pin_assigned(pin_assigned));

// ===== ppx_pin_env.sv
// Board around the port pins: pull-ups and an optional outside driver.
// Assumes the bench sets which pins the outside drives and to what.
`timescale 1ns/10ps
module ppx_pin_env (
   input wire ppx_pkg::ppx_pin_drive_s pin_drive,
   input wire logic [28:0] ext_drv,
   input wire logic [28:0] ext_val,
   output logic [28:0] pin_in
);
   // Device low wins, else outside driver, else high or pull-up
   assign pin_in = ~(pin_drive.enable & ~pin_drive.level)
      & (~ext_drv | ext_val);
endmodule // ppx_pin_env

// ===== ppx_crossbar_tb.sv
// Self-checking bench for the priority pin crossbar.
// Assumes ppx_pkg, ppx_crossbar and ppx_pin_env are compiled first.
`timescale 1ns/10ps
module ppx_crossbar_tb;
   import ppx_pkg::*;
   logic clk_sys, resetn;
   ppx_cfg_s cfg;
   ppx_fn_drive_s fn_drive;
   ppx_pin_drive_s pin_drive;
   logic [28:0] pin_in, port_read, pin_assigned, ext_drv, ext_val, pin_s, ea;
   logic [20:0] fn_in;
   int n_mismatch = 0, check_count = 0;
   int pin_of [21];
   ppx_crossbar dut_u (.clk_sys(clk_sys), .resetn(resetn), .cfg(cfg),
      .fn_drive(fn_drive), .pin_in(pin_in), .pin_drive(pin_drive),
      .port_read(port_read), .fn_in(fn_in), .pin_assigned(pin_assigned));
   ppx_pin_env env_u (.pin_drive(pin_drive), .ext_drv(ext_drv),
      .ext_val(ext_val), .pin_in(pin_in));
   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(string nm, logic [28:0] seen, logic [28:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Expected placement into ea and pin_of
   function automatic void place(ppx_cfg_s c);
      logic [7:0] lo, hi;
      logic [2:0] k;
      logic [20:0] w;
      int p;
      lo = c.function_select_low;
      hi = c.function_select_high;
      k = (hi[2:0] > 3'h5) ? 3'h5 : hi[2:0];
      w = {hi[5:3], 5'((6'h1 << k) - 6'h1), lo[3], lo[7:4], {2{lo[2]}},
         lo[1] & c.spi_four_wire, {3{lo[1]}}, {2{lo[0]}}};
      if (!hi[6]) w = '0;
      p = 0;
      ea = '0;
      foreach (pin_of[f]) pin_of[f] = -1;
      if (w[0]) begin
         ea[5:4] = 2'b11;
         pin_of[0] = 4;
         pin_of[1] = 5;
      end
      for (int f = 2; f < 21; f++) if (w[f]) begin
         while (p < 20 && (ea[p] || c.port_skip_mask[p])) p++;
         if (p < 20) begin
            ea[p] = 1'b1;
            pin_of[f] = p;
         end
      end
   endfunction
   task automatic step(logic [7:0] lo, logic [7:0] hi, logic [23:0] sk,
         logic fw);
      logic [28:0] el, ee, md;
      logic [20:0] efn;
      int p;
      @(posedge clk_sys);
      cfg <= '{lo, hi, sk, 29'($urandom), 29'($urandom), fw};
      fn_drive <= '{21'($urandom), 21'($urandom) & 21'h03fffd};
      ext_drv <= 29'($urandom) & 29'($urandom);
      ext_val <= 29'($urandom);
      @(negedge clk_sys);
      pin_s = pin_in;
      place(cfg);
      el = cfg.port_latch;
      ee = '1;
      md = cfg.port_output_mode;
      for (int f = 0; f < 21; f++) begin
         p = pin_of[f];
         efn[f] = (p < 0) ? 1'b1 : pin_s[p];
         if (p >= 0) begin
            ee[p] = fn_drive.drive[f];
            el[p] = fn_drive.value[f];
            if (f == 6 || f == 7) md[p] = 1'b0;
         end
      end
      ee = cfg.function_select_high[6] ? ee & (md | ~el) : '0;
      @(posedge clk_sys);
      #1;
      chk("assigned", pin_assigned, ea);
      chk("port_read", port_read, pin_s);
      chk("fn_in", 29'(fn_in), 29'(efn));
      chk("enable", pin_drive.enable, ee);
      chk("level", pin_drive.level & pin_drive.enable, el & md & ee);
   endtask
   initial begin
      #1000000 n_mismatch++;
      end_sim();
   end
   initial begin
      cfg = '0;
      fn_drive = '0;
      ext_drv = '0;
      ext_val = '0;
      resetn = 0;
      void'($urandom(2588));
      repeat (2) @(posedge clk_sys);
      resetn <= 1;
      step(8'h01, 8'h40, 24'h000030, 1'b0);
      step(8'h02, 8'h40, 24'h0, 1'b0);
      step(8'h02, 8'h40, 24'h0, 1'b1);
      step(8'h02, 8'h40, 24'h00000c, 1'b1);
      step(8'h04, 8'h40, 24'h0, 1'b0);
      step(8'hff, 8'h7f, 24'h00c000, 1'b1);
      step(8'hff, 8'h3f, 24'h0, 1'b1);
      for (int k = 0; k < 8; k++) step(8'h08, 8'(8'h40 + k), 24'h0, 1'b0);
      for (int i = 0; i < 300; i++) begin
         if (i == 150) begin
            @(posedge clk_sys) resetn <= 0;
            @(posedge clk_sys) #1;
            chk("reset", pin_assigned | pin_drive.enable, '0);
            @(posedge clk_sys) resetn <= 1;
         end
         step(8'($urandom), {1'b0, 1'($urandom % 4 != 0), 6'($urandom)},
            24'($urandom & $urandom & $urandom), 1'($urandom));
      end
      end_sim();
   end
endmodule // ppx_crossbar_tb
